// ---- rtl/spps_params.svh ----
`ifndef SPPS_PARAMS_SVH
`define SPPS_PARAMS_SVH
// Clock period in ns
`define SPPS_CLK_PERIOD_NS 8
// Supply transition timer limit in us and in cycles (longest time, rounds down)
`define SPPS_SUPPLY_TRANSITION_TIME_US 500
`define SPPS_SUPPLY_TRANSITION_CYC ((`SPPS_SUPPLY_TRANSITION_TIME_US * 1000) / `SPPS_CLK_PERIOD_NS)
// Fast swap source deadline in us and in cycles (longest time, rounds down)
`define SPPS_FAST_SWAP_DEADLINE_US 15
`define SPPS_FAST_SWAP_DEADLINE_CYC ((`SPPS_FAST_SWAP_DEADLINE_US * 1000) / `SPPS_CLK_PERIOD_NS)
// Re-engagements after recovery, counting the one that latches off
`define SPPS_RETRY_LIMIT_DEF 2
`define SPPS_RETRY_W 4
`define SPPS_TMR_W 20
// Message codes on the receive/transmit message ports
`define SPPS_MSG_W 4
`define SPPS_MSG_ACCEPT 4'h3
`define SPPS_MSG_PS_RDY 4'h6
`define SPPS_MSG_GOODCRC 4'h1
`endif

// ---- rtl/spps_pkg.sv ----
`include "spps_params.svh"
package spps_pkg;
    typedef enum logic [3:0] {
        SPPS_IDLE      = 4'h0,
        SPPS_HARD_RST  = 4'h1,
        SPPS_WAIT_SAFE = 4'h2,
        SPPS_COOLING   = 4'h3,
        SPPS_DEFAULT   = 4'h4,
        SPPS_ACK_ACC   = 4'h5,
        SPPS_WAIT_RDY  = 4'h6,
        SPPS_ACK_RDY   = 4'h7,
        SPPS_FRS_HOLD  = 4'h8,
        SPPS_FRS_SRC   = 4'h9,
        SPPS_FRS_RDY   = 4'hA,
        SPPS_SOURCE    = 4'hB,
        SPPS_LATCHED   = 4'hC
    } spps_state_e;
    typedef logic [`SPPS_MSG_W-1:0] spps_msg_t;
    typedef logic [`SPPS_RETRY_W-1:0] spps_cnt_t;
endpackage

// ---- rtl/spps_sync.sv ----
module spps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            sync_o <= '0;
        end else begin
            meta_ff <= async_i;
            sync_o <= meta_ff;
        end
    end
endmodule

// ---- rtl/spps_sequencer.sv ----
`include "spps_params.svh"
// Overview of operation
// [R1] Over-voltage response never changes the contract voltage request.
// [R2] Over-voltage engagement requests Hard Reset signaling toward the source.
// [R3] After over-voltage, return to default once safe default bus voltage is back.
// [R4] After recovery the sink may renegotiate a new contract.
// [R5] Recurring protection after recovery stops cycling by latching off.
// [R6] Over-temperature engagement requests Hard Reset signaling toward the source.
// [R7] After over-temperature, resume default once cooled.
// [R8] On fast swap signal stop sinking and prepare to source default voltage.
// [R9] Below safe minimum, enable source output within the fast swap deadline.
// [R10] Bus discharge stays disabled throughout the fast swap role change.
// [R11] New source advertises the fast swap current level it announced.
// [R12] After fast swap, act as an ordinary source.
// [R13] Once sourcing after fast swap, send PS_RDY to the hub port.
// [R14] First contract from legacy mode uses the same transition sequence.
// [R15] On Accept start the supply transition timer.
// [R16] Acknowledge Accept and PS_RDY with GoodCRC before evaluating them.
// [R17] Source waits its change time after GoodCRC before changing power.
// [R18] Source becomes ready within limit, then sends PS_RDY expecting GoodCRC.
// [R19] After evaluating PS_RDY, grant use of the new power level.
// [R20] Hold transient load limit while moving to the new power level.
// [R21] Count re-engagements; latch off at threshold until detach or reset.
// [R22] Timer expiry before PS_RDY fails the transition and requests Hard Reset.
module spps_sequencer
    import spps_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ovp_i,
    input wire logic otp_i,
    input wire logic cooled_i,
    input wire logic vbus_safe_i,
    input wire logic vbus_below_min_i,
    input wire logic attached_i,
    input wire logic frs_signal_i,
    input wire logic frs_capable_i,
    input wire logic [1:0] frs_current_i,
    input wire logic [`SPPS_RETRY_W-1:0] retry_limit_i,
    input wire logic rx_valid_i,
    input wire spps_pkg::spps_msg_t rx_msg_i,
    input wire logic tx_done_i,
    input wire logic hard_reset_done_i,
    output logic tx_valid_o,
    output spps_pkg::spps_msg_t tx_msg_o,
    output logic hard_reset_req_o,
    output logic sink_enable_o,
    output logic source_enable_o,
    output logic discharge_en_o,
    output logic [1:0] src_current_o,
    output logic new_power_ok_o,
    output logic load_limit_o,
    output logic negotiation_allowed_o,
    output logic latched_off_o,
    output logic source_role_o,
    output logic transition_fail_o
);
    import spps_pkg::*;

    localparam logic [`SPPS_TMR_W-1:0] SUPPLY_TRANSITION_CYC = `SPPS_TMR_W'(`SPPS_SUPPLY_TRANSITION_CYC);
    localparam logic [`SPPS_TMR_W-1:0] FAST_SWAP_CYC = `SPPS_TMR_W'(`SPPS_FAST_SWAP_DEADLINE_CYC);

    logic ovp_s, otp_s, cooled_s, safe_s, below_s, attached_s, frs_s;
    logic ovp_d_ff, otp_d_ff, frs_d_ff;
    logic ovp_rise, otp_rise, fault_rise, frs_rise;
    spps_state_e state_ff, nxt_state;
    logic [`SPPS_TMR_W-1:0] tmr_ff, nxt_tmr;
    spps_cnt_t retry_ff;
    logic recovered_ff;
    logic ot_fault_ff;
    logic prot_ff;
    logic ps_rdy_seen_ff;
    logic [1:0] frs_cur_ff;
    logic tx_fire;
    logic rx_accept, rx_ps_rdy;

    spps_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .async_i({ovp_i, otp_i, cooled_i, vbus_safe_i, vbus_below_min_i, attached_i, frs_signal_i}),
        .sync_o({ovp_s, otp_s, cooled_s, safe_s, below_s, attached_s, frs_s})
    );

    // Edge detectors on synchronised fault and fast swap levels
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ovp_d_ff <= 1'b0;
            otp_d_ff <= 1'b0;
            frs_d_ff <= 1'b0;
        end else begin
            ovp_d_ff <= ovp_s;
            otp_d_ff <= otp_s;
            frs_d_ff <= frs_s;
        end
    end

    assign ovp_rise = ovp_s && !ovp_d_ff;
    assign otp_rise = otp_s && !otp_d_ff;
    assign fault_rise = ovp_rise || otp_rise;
    assign frs_rise = frs_s && !frs_d_ff && frs_capable_i;
    assign rx_accept = rx_valid_i && (rx_msg_i == `SPPS_MSG_ACCEPT);
    assign rx_ps_rdy = rx_valid_i && (rx_msg_i == `SPPS_MSG_PS_RDY);
    assign tx_fire = tx_valid_o && tx_done_i;

    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tmr_ff;
        unique case (state_ff)
            SPPS_IDLE, SPPS_DEFAULT: begin
                if (rx_accept) begin
                    nxt_state = SPPS_ACK_ACC; // R16
                end
            end
            SPPS_ACK_ACC: begin
                if (tx_fire) begin
                    nxt_state = SPPS_WAIT_RDY;
                end
            end
            SPPS_WAIT_RDY: begin
                if (rx_ps_rdy) begin
                    nxt_state = SPPS_ACK_RDY; // R16
                end else if (tmr_ff == '0) begin
                    nxt_state = SPPS_HARD_RST; // R22
                end else begin
                    nxt_tmr = tmr_ff - `SPPS_TMR_W'(1);
                end
            end
            SPPS_ACK_RDY: begin
                if (tx_fire) begin
                    nxt_state = SPPS_DEFAULT; // R19
                end
            end
            SPPS_HARD_RST: begin
                if (hard_reset_done_i) begin
                    nxt_state = ot_fault_ff ? SPPS_COOLING : SPPS_WAIT_SAFE;
                end
            end
            SPPS_WAIT_SAFE: begin
                if (safe_s && !ovp_s) begin
                    nxt_state = SPPS_DEFAULT; // R3
                end
            end
            SPPS_COOLING: begin
                if (cooled_s && !otp_s) begin
                    nxt_state = SPPS_DEFAULT; // R7
                end
            end
            SPPS_FRS_HOLD: begin
                if (below_s) begin
                    nxt_state = SPPS_FRS_SRC; // R9
                    nxt_tmr = FAST_SWAP_CYC;
                end
            end
            SPPS_FRS_SRC: begin
                nxt_state = SPPS_FRS_RDY; // R13
            end
            SPPS_FRS_RDY: begin
                if (tx_fire) begin
                    nxt_state = SPPS_SOURCE; // R12
                end
            end
            SPPS_SOURCE: begin
                nxt_state = SPPS_SOURCE;
            end
            SPPS_LATCHED: begin
                nxt_state = SPPS_LATCHED;
            end
            default: begin
                nxt_state = SPPS_IDLE;
            end
        endcase
        if (rx_accept && (state_ff == SPPS_IDLE || state_ff == SPPS_DEFAULT)) begin
            nxt_tmr = SUPPLY_TRANSITION_CYC; // R15
        end
        // Fast swap beats an ordinary sink sequence
        if (frs_rise && state_ff != SPPS_LATCHED && state_ff != SPPS_SOURCE &&
            state_ff != SPPS_FRS_SRC && state_ff != SPPS_FRS_RDY) begin
            nxt_state = SPPS_FRS_HOLD; // R8
        end
        // Protection beats fast swap; only a detach outside the fast swap states and SPPS_SOURCE ranks higher
        if (fault_rise && state_ff != SPPS_LATCHED) begin
            if (recovered_ff && (retry_ff + spps_cnt_t'(1)) >= retry_limit_i) begin
                nxt_state = SPPS_LATCHED; // R5 R21
            end else begin
                nxt_state = SPPS_HARD_RST; // R2 R6
            end
        end
        if (!attached_s && state_ff != SPPS_FRS_HOLD && state_ff != SPPS_FRS_SRC &&
            state_ff != SPPS_FRS_RDY && state_ff != SPPS_SOURCE) begin
            nxt_state = SPPS_IDLE; // R21
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_ff <= SPPS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tmr_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
        end
    end

    // Re-engagement bookkeeping, cleared only by detach or reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || !attached_s) begin
            retry_ff <= '0;
            recovered_ff <= 1'b0;
        end else begin
            if (nxt_state == SPPS_DEFAULT && prot_ff &&
                (state_ff == SPPS_WAIT_SAFE || state_ff == SPPS_COOLING)) begin
                recovered_ff <= 1'b1; // R5
            end
            if (fault_rise && recovered_ff && state_ff != SPPS_LATCHED) begin
                retry_ff <= retry_ff + spps_cnt_t'(1); // R21
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ot_fault_ff <= 1'b0;
        end else if (fault_rise) begin
            ot_fault_ff <= otp_rise;
        end else if (state_ff == SPPS_WAIT_RDY && nxt_state == SPPS_HARD_RST) begin
            ot_fault_ff <= 1'b0;
        end
    end

    // Only a recovery from a protection episode arms the re-engagement count
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            prot_ff <= 1'b0;
        end else if (fault_rise) begin
            prot_ff <= 1'b1;
        end else if (state_ff == SPPS_WAIT_RDY && nxt_state == SPPS_HARD_RST) begin
            prot_ff <= 1'b0; // R21
        end
    end

    // Advertised fast swap current captured when the swap starts
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            frs_cur_ff <= 2'h0;
        end else if (nxt_state == SPPS_FRS_HOLD && state_ff != SPPS_FRS_HOLD) begin
            frs_cur_ff <= frs_current_i; // R11
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ps_rdy_seen_ff <= 1'b0;
        end else if (state_ff == SPPS_ACK_RDY && tx_fire) begin
            ps_rdy_seen_ff <= 1'b1; // R19
        end else if (rx_accept || nxt_state != SPPS_DEFAULT) begin
            ps_rdy_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            transition_fail_o <= 1'b0;
        end else begin
            transition_fail_o <= (state_ff == SPPS_WAIT_RDY) && !rx_ps_rdy && (tmr_ff == '0); // R22
        end
    end

    // Outputs registered from the next state
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sink_enable_o <= 1'b0;
        end else begin
            sink_enable_o <= (nxt_state == SPPS_IDLE || nxt_state == SPPS_DEFAULT ||
                              nxt_state == SPPS_ACK_ACC || nxt_state == SPPS_WAIT_RDY ||
                              nxt_state == SPPS_ACK_RDY) && attached_s; // R8
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            source_enable_o <= 1'b0;
        end else begin
            source_enable_o <= (nxt_state == SPPS_FRS_SRC || nxt_state == SPPS_FRS_RDY ||
                                nxt_state == SPPS_SOURCE); // R9
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            source_role_o <= 1'b0;
        end else begin
            source_role_o <= (nxt_state == SPPS_FRS_HOLD || nxt_state == SPPS_FRS_SRC ||
                              nxt_state == SPPS_FRS_RDY || nxt_state == SPPS_SOURCE);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            latched_off_o <= 1'b0;
        end else begin
            latched_off_o <= (nxt_state == SPPS_LATCHED);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            negotiation_allowed_o <= 1'b0;
        end else begin
            negotiation_allowed_o <= (nxt_state == SPPS_IDLE || nxt_state == SPPS_DEFAULT) && attached_s; // R4 R14
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            load_limit_o <= 1'b0;
        end else begin
            load_limit_o <= (nxt_state == SPPS_ACK_ACC || nxt_state == SPPS_WAIT_RDY ||
                             nxt_state == SPPS_ACK_RDY); // R20
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            hard_reset_req_o <= 1'b0;
        end else begin
            hard_reset_req_o <= (nxt_state == SPPS_HARD_RST); // R2 R6
        end
    end

    assign new_power_ok_o = ps_rdy_seen_ff && (state_ff == SPPS_DEFAULT); // R19
    assign discharge_en_o = 1'b0; // R10
    assign src_current_o = source_role_o ? frs_cur_ff : 2'h0; // R11
    // Protection touches no contract voltage output; it opens the sink path, or the source path in the source role
    assign tx_valid_o = (state_ff == SPPS_ACK_ACC || state_ff == SPPS_ACK_RDY || state_ff == SPPS_FRS_RDY); // R1
    assign tx_msg_o = (state_ff == SPPS_FRS_RDY) ? `SPPS_MSG_PS_RDY : `SPPS_MSG_GOODCRC; // R13 R16
endmodule

// ---- verif/spps_chk.sv ----
`include "spps_params.svh"
module spps_chk
    import spps_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ovp_i,
    input wire logic otp_i,
    input wire logic vbus_below_min_i,
    input wire logic rx_valid_i,
    input wire logic tx_done_i,
    input wire logic tx_valid_o,
    input wire spps_pkg::spps_msg_t tx_msg_o,
    input wire logic hard_reset_req_o,
    input wire logic sink_enable_o,
    input wire logic source_enable_o,
    input wire logic discharge_en_o,
    input wire logic [1:0] src_current_o,
    input wire logic new_power_ok_o,
    input wire logic latched_off_o,
    input wire logic source_role_o,
    input wire logic transition_fail_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    a_discharge_off: assert property (discharge_en_o == 1'b0) else $error("discharge on");
    a_ack_before_eval: assert property ($rose(tx_valid_o) && tx_msg_o == `SPPS_MSG_GOODCRC |->
        $past(rx_valid_i)) else $error("ack without message");
    a_grant_after_ack: assert property ($rose(new_power_ok_o) |-> $past(tx_done_i)) else $error("early grant");
    a_fail_hard_rst: assert property (transition_fail_o |-> ##[0:1] hard_reset_req_o) else $error("no reset");
    a_fault_reset_req: assert property (($rose(ovp_i) || $rose(otp_i)) && !hard_reset_req_o && !latched_off_o
        && !source_role_o |-> ##[3:6] (hard_reset_req_o || latched_off_o)) else $error("fault ignored");
    a_sink_off_swap: assert property (source_role_o |-> !sink_enable_o) else $error("sinking as source");
    a_src_deadline: assert property (source_role_o && $rose(vbus_below_min_i) |-> ##[1:6] source_enable_o)
        else $error("source late");
    a_current_hold: assert property (source_role_o && $past(source_role_o) |-> $stable(src_current_o))
        else $error("current changed");
    a_ready_sent: assert property ($rose(source_enable_o) && source_role_o |->
        ##[0:2] (tx_valid_o && tx_msg_o == `SPPS_MSG_PS_RDY)) else $error("no ready message");
    a_latched_idle: assert property (latched_off_o |-> !sink_enable_o && !source_enable_o)
        else $error("latched but powered");
    c_grant: cover property ($rose(new_power_ok_o));
    c_fail: cover property (transition_fail_o);
    c_latch: cover property ($rose(latched_off_o));
    c_swap: cover property ($rose(source_enable_o));
endmodule
bind spps_sequencer spps_chk u_chk (.*);

// ---- verif/spps_src_model.sv ----
`include "spps_params.svh"
module spps_src_model
    import spps_pkg::*;
#(
    parameter int CHANGE_CYC = 20,
    parameter int READY_CYC = 30
) (
    input wire logic clk_sys_i,
    input wire logic tx_valid_i,
    input wire spps_pkg::spps_msg_t tx_msg_i,
    output logic rx_valid_o,
    output spps_pkg::spps_msg_t rx_msg_o,
    output logic tx_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_ack = 0;
    spps_msg_t last_tx = 4'h0;
    initial begin
        rx_valid_o = 1'b0;
        rx_msg_o = 4'hF;
        tx_done_o = 1'b0;
    end
    // Link takes each transmit request at the first falling clock edge, half a cycle after it appears
    always @(negedge clk_sys_i) begin
        tx_done_o <= tx_valid_i && !tx_done_o;
        if (tx_valid_i && !tx_done_o) begin
            last_tx <= tx_msg_i;
            n_ack <= n_ack + 1;
        end
    end
    task automatic send(input spps_msg_t m);
        @(negedge clk_sys_i);
        rx_valid_o = 1'b1;
        rx_msg_o = m;
        @(negedge clk_sys_i);
        rx_valid_o = 1'b0;
        rx_msg_o = ~m;
    endtask
    // Same sequence for first and later contracts
    task automatic exchange(input bit give_rdy);
        send(`SPPS_MSG_ACCEPT);
        repeat (CHANGE_CYC) @(negedge clk_sys_i);
        repeat (READY_CYC) @(negedge clk_sys_i);
        if (give_rdy) begin
            send(`SPPS_MSG_PS_RDY);
        end
    endtask
endmodule

// ---- verif/tb_sink_power_policy_sequencer.sv ----
`include "spps_params.svh"
module tb_sink_power_policy_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import spps_pkg::*;
    logic clk_sys_i = 0, rst_b_i = 0, ovp_i = 0, otp_i = 0, cooled_i = 1, vbus_safe_i = 1, vbus_below_min_i = 0;
    logic attached_i = 1, frs_signal_i = 0, frs_capable_i = 0, hard_reset_done_i = 0;
    logic [1:0] frs_current_i = 2'h0;
    logic [3:0] retry_limit_i = 4'(`SPPS_RETRY_LIMIT_DEF);
    logic rx_valid_i, tx_done_i, tx_valid_o, hard_reset_req_o, sink_enable_o, source_enable_o, discharge_en_o;
    logic new_power_ok_o, load_limit_o, negotiation_allowed_o, latched_off_o, source_role_o, transition_fail_o;
    spps_msg_t rx_msg_i, tx_msg_o;
    logic [1:0] src_current_o;
    int n_mismatch = 0, total_checks = 0, cyc = 0, k, n;
    spps_sequencer u_dut (.*);
    spps_src_model u_src (.clk_sys_i(clk_sys_i), .tx_valid_i(tx_valid_o), .tx_msg_i(tx_msg_o),
        .rx_valid_o(rx_valid_i), .rx_msg_o(rx_msg_i), .tx_done_o(tx_done_i));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
            n_mismatch++;
        end
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic hr_done;
        for (k = 0; k < 10 && !hard_reset_req_o; k++) @(negedge clk_sys_i);
        chk(hard_reset_req_o, 1);
        hard_reset_done_i = 1;
        @(negedge clk_sys_i);
        hard_reset_done_i = 0;
    endtask
    task automatic t_incr;
        n = u_src.n_ack;
        fork
            u_src.exchange(1);
            begin
                repeat (6) @(negedge clk_sys_i);
                chk(load_limit_o, 1);
                chk(new_power_ok_o, 0);
                chk(u_src.last_tx, `SPPS_MSG_GOODCRC);
            end
        join
        repeat (4) @(negedge clk_sys_i);
        chk(u_src.n_ack - n, 2);
        chk(load_limit_o, 0);
        chk(new_power_ok_o, 1);
        chk(transition_fail_o, 0);
    endtask
    task automatic t_timeout;
        u_src.exchange(0);
        repeat (`SPPS_SUPPLY_TRANSITION_CYC - 100) @(negedge clk_sys_i);
        chk(hard_reset_req_o, 0);
        for (k = 0; k < 200 && !transition_fail_o; k++) @(negedge clk_sys_i);
        chk(transition_fail_o, 1);
        hr_done();
        for (k = 0; k < 20 && !negotiation_allowed_o; k++) @(negedge clk_sys_i);
    endtask
    task automatic t_ovp;
        vbus_safe_i = 0;
        ovp_i = 1;
        hr_done();
        ovp_i = 0;
        repeat (5) @(negedge clk_sys_i);
        vbus_safe_i = 1;
        for (k = 0; k < 20 && !negotiation_allowed_o; k++) @(negedge clk_sys_i);
        chk(negotiation_allowed_o, 1);
    endtask
    task automatic t_otp_latch;
        for (n = 0; n < 3 && !latched_off_o; n++) begin
            cooled_i = 0;
            otp_i = 1;
            for (k = 0; k < 10 && !hard_reset_req_o && !latched_off_o; k++) @(negedge clk_sys_i);
            if (!latched_off_o) begin
                hr_done();
                otp_i = 0;
                repeat (5) @(negedge clk_sys_i);
                cooled_i = 1;
                for (k = 0; k < 20 && !negotiation_allowed_o; k++) @(negedge clk_sys_i);
                chk(negotiation_allowed_o, 1);
            end
        end
        chk(latched_off_o, 1);
        otp_i = 0;
        cooled_i = 1;
        attached_i = 0;
        repeat (8) @(negedge clk_sys_i);
        chk(latched_off_o, 0);
        attached_i = 1;
        repeat (8) @(negedge clk_sys_i);
    endtask
    task automatic t_swap;
        frs_capable_i = 1;
        frs_current_i = 2'h2;
        frs_signal_i = 1;
        for (k = 0; k < 10 && !source_role_o; k++) @(negedge clk_sys_i);
        chk(sink_enable_o, 0);
        frs_current_i = 2'h1;
        vbus_below_min_i = 1;
        for (k = 0; k < `SPPS_FAST_SWAP_DEADLINE_CYC && !source_enable_o; k++) @(negedge clk_sys_i);
        chk(source_enable_o, 1);
        chk(discharge_en_o, 0);
        repeat (6) @(negedge clk_sys_i);
        chk(u_src.last_tx, `SPPS_MSG_PS_RDY);
        chk(src_current_o, 2'h2);
        chk(source_role_o, 1);
    endtask
    initial begin
        repeat (4) @(negedge clk_sys_i);
        rst_b_i = 1;
        repeat (4) @(negedge clk_sys_i);
        t_incr();
        t_timeout();
        t_ovp();
        t_incr();
        t_otp_latch();
        t_swap();
        stop_test();
    end
endmodule
